/* File: sps_pkg.sv */
/*
  Shared constants, carrier structs and state encodings of the serial port.
  Assumes a single system clock domain plus the link clock taken from the pin.
*/
package sps_pkg;

  // ----------------------------------------------------------------------
  // Sizes and fixed values
  // ----------------------------------------------------------------------
  localparam int         FIFO_BYTES = 32;
  localparam int         CNT_W      = 6;
  localparam logic [7:0] IDLE_BYTE  = 8'hFF;
  localparam logic [3:0] SCALE_MAX  = 4'h8;
  localparam logic [1:0] SIZE_8     = 2'h0;
  localparam logic [1:0] SIZE_16    = 2'h1;
  localparam logic [1:0] SIZE_32    = 2'h2;

  // ----------------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------------
  localparam int NUM_FLAGS   = 12;
  localparam int FL_TX_EMPTY = 0;
  localparam int FL_TX_LEVEL = 1;
  localparam int FL_RX_FULL  = 2;
  localparam int FL_RX_LEVEL = 3;
  localparam int FL_TX_UNDER = 4;
  localparam int FL_TX_OVER  = 5;
  localparam int FL_RX_UNDER = 6;
  localparam int FL_RX_OVER  = 7;
  localparam int FL_SS_EDGE  = 8;
  localparam int FL_DONE     = 9;
  localparam int FL_ABORT    = 10;
  localparam int FL_MM_FAULT = 11;

  localparam int NUM_WAKE    = 4;
  localparam int WK_RX_FULL  = 0;
  localparam int WK_TX_EMPTY = 1;
  localparam int WK_RX_LEVEL = 2;
  localparam int WK_TX_LEVEL = 3;

  // ----------------------------------------------------------------------
  // Synchroniser bit positions
  // ----------------------------------------------------------------------
  localparam int SY_SS   = 0;
  localparam int SY_MOSI = 1;
  localparam int SY_MISO = 2;
  localparam int SY_TS   = 3;
  localparam int SY_TD   = 4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE, M_LEAD, M_LOAD, M_FETCH, M_A, M_B, M_DONE
  } sps_mst_t;

  typedef struct packed {
    logic        port_en;
    logic        controller_role_sel;
    logic        three_wire;
    logic        ss_act_high;
    logic        cpol;
    logic        cpha;
    logic        ss_hold;
    logic        slave_3w_tx;
    logic [3:0]  scale;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [15:0] tx_chars;
    logic [15:0] rx_chars;
    logic [5:0]  tx_lvl;
    logic [5:0]  rx_lvl;
  } sps_cfg_t;

  typedef struct packed {
    logic ss_o;
    logic ss_oe;
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } sps_pins_t;

  typedef struct packed {
    logic        en;
    logic [1:0]  size;
    logic [1:0]  addr;
    logic [31:0] data;
  } sps_wr_t;

  typedef struct packed {
    logic       en;
    logic [1:0] size;
  } sps_rd_t;

endpackage : sps_pkg

/* File: sps_fifo_mem.sv */
/*
  Byte FIFO with registered read data, used for both directions.
  Assumes push and pop come from logic on the same clock.
*/
`timescale 1ns/100ps
module sps_fifo_mem
  import sps_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = FIFO_BYTES,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         push,
  input  wire logic [W-1:0] wdata,
  input  wire logic         pop,
  output logic      [W-1:0] rdata,
  output logic      [AW:0]  count,
  output logic              full,
  output logic              empty
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic [W-1:0]  rd;
  } sps_fst_t;

  sps_fst_t       r;
  sps_fst_t       n;
  logic [W-1:0]   mem [DEPTH];
  logic           do_push;
  logic           do_pop;

  assign full  = (r.cnt == (AW+1)'(DEPTH));
  assign empty = (r.cnt == '0);
  assign count = r.cnt;
  assign rdata = r.rd;
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;

  always_comb begin
    n = r;
    if (do_push) n.wp = r.wp + 1'b1;
    if (do_pop) begin
      n.rp = r.rp + 1'b1;
      n.rd = mem[r.rp];
    end
    n.cnt = r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) r <= '0;
    else if (ce) r <= n;
  end

  always_ff @(posedge clk) begin
    if (ce && do_push) mem[r.wp] <= wdata;
  end
endmodule : sps_fifo_mem

/* File: sps_slave_link.sv */
/*
  Slave shifter clocked by the serial clock pin.
  Assumes frame_rstn is low outside a selected frame and the mode is static.
*/
`timescale 1ns/100ps
module sps_slave_link (
  input  wire logic       link_clk,
  input  wire logic       frame_rstn,
  input  wire logic       rstn,
  input  wire logic       invert,
  input  wire logic       din,
  input  wire logic [7:0] hold,
  output logic            out_bit,
  output logic [7:0]      rx_byte,
  output logic            tog_start,
  output logic            tog_done
);
  logic       eff_clk;
  logic [2:0] bit_reg;
  logic [7:0] shin_reg;
  logic [7:0] shout_reg;

  // Sample edge is always the rising edge of eff_clk
  assign eff_clk = link_clk ^ invert;
  assign out_bit = (bit_reg == 3'h0) ? hold[7] : shout_reg[~bit_reg];

  always_ff @(posedge eff_clk or negedge frame_rstn) begin
    if (!frame_rstn) begin
      bit_reg   <= 3'h0;
      shin_reg  <= 8'h00;
      shout_reg <= 8'h00;
    end else begin
      bit_reg  <= bit_reg + 3'h1;
      shin_reg <= {shin_reg[6:0], din};
      if (bit_reg == 3'h0) shout_reg <= hold;
    end
  end

  // Toggles survive the frame so the system side can compare them
  always_ff @(posedge eff_clk or negedge rstn) begin
    if (!rstn) begin
      rx_byte   <= 8'h00;
      tog_start <= 1'b0;
      tog_done  <= 1'b0;
    end else begin
      // Edges while deselected belong to another slave
      if (frame_rstn && bit_reg == 3'h0) tog_start <= ~tog_start;
      if (bit_reg == 3'h7) begin
        rx_byte  <= {shin_reg[6:0], din};
        tog_done <= ~tog_done;
      end
    end
  end
endmodule : sps_slave_link

/* File: sps_port.sv */
/*
  Serial peripheral port: master engine, slave crossing, FIFOs, flags, wake.
  Assumes static configuration during a frame and an external pull on select.
*/
`timescale 1ns/100ps
module sps_port
  import sps_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic                 link_sclk,
  input  wire logic                 ss_in,
  input  wire logic                 mosi_in,
  input  wire logic                 miso_in,
  output sps_pins_t                 pins,
  input  wire sps_cfg_t             cfg,
  input  wire logic                 start_req,
  output logic                      start_pending,
  output logic                      xfer_active,
  input  wire sps_wr_t              wr,
  output logic                      wr_busy,
  input  wire sps_rd_t              rd,
  output logic                      rd_busy,
  output logic                      rd_valid,
  output logic [31:0]               rd_data,
  input  wire logic [NUM_FLAGS-1:0] flag_clr,
  output logic [NUM_FLAGS-1:0]      flags,
  input  wire logic [NUM_WAKE-1:0]  wake_en,
  input  wire logic [NUM_WAKE-1:0]  wake_clr,
  output logic [NUM_WAKE-1:0]       wake_flags,
  output logic                      wake,
  output logic [CNT_W-1:0]          tx_count,
  output logic [CNT_W-1:0]          rx_count
);
  typedef struct packed {
    logic [4:0]           s1;
    logic [4:0]           s2;
    logic                 ss_p;
    logic                 ts_p;
    logic                 td_p;
    sps_mst_t             mst;
    logic [7:0]           psc;
    logic [7:0]           hcnt;
    logic [2:0]           bitn;
    logic [15:0]          txl;
    logic [15:0]          rxl;
    logic                 cur_tx;
    logic                 sclk_act;
    logic                 mosi_r;
    logic                 ss_drv;
    logic [7:0]           shout;
    logic [7:0]           shin;
    logic                 start_r;
    logic [7:0]           hold;
    logic                 hold_full;
    logic                 refill;
    logic [31:0]          stg;
    logic [2:0]           stg_n;
    logic [7:0]           plo;
    logic [7:0]           phi;
    logic                 plo_v;
    logic                 phi_v;
    logic [31:0]          rdat;
    logic [2:0]           rd_left;
    logic [1:0]           rd_idx;
    logic                 rd_cap;
    logic                 rd_v;
    logic [NUM_FLAGS-1:0] flg;
    logic [NUM_WAKE-1:0]  wflg;
    logic                 txe_p;
    logic                 rxf_p;
    logic                 txl_p;
    logic                 rxl_p;
    logic [1:0]           prime;
    logic [1:0]           drv_h;
  } sps_st_t;

  sps_st_t    r;
  sps_st_t    n;
  logic       tx_push;
  logic       tx_pop;
  logic       rx_push;
  logic       rx_pop;
  logic [7:0] rx_wd;
  logic [7:0] tx_rd;
  logic [7:0] rx_rd;
  logic       tx_full;
  logic       tx_empty;
  logic       rx_full;
  logic       rx_empty;
  logic       slave_out;
  logic [7:0] link_rx;
  logic       tog_start;
  logic       tog_done;
  logic       master;
  logic       slave;
  logic       frame_rstn;

  // ----------------------------------------------------------------------
  // FIFOs and slave shifter
  // ----------------------------------------------------------------------
  sps_fifo_mem #(.W(8), .DEPTH(FIFO_BYTES)) u_txf (
    .clk   (clk),
    .rstn  (rstn),
    .ce    (ce),
    .push  (tx_push),
    .wdata (r.stg[7:0]),
    .pop   (tx_pop),
    .rdata (tx_rd),
    .count (tx_count),
    .full  (tx_full),
    .empty (tx_empty)
  );

  sps_fifo_mem #(.W(8), .DEPTH(FIFO_BYTES)) u_rxf (
    .clk   (clk),
    .rstn  (rstn),
    .ce    (ce),
    .push  (rx_push),
    .wdata (rx_wd),
    .pop   (rx_pop),
    .rdata (rx_rd),
    .count (rx_count),
    .full  (rx_full),
    .empty (rx_empty)
  );

  assign master = cfg.port_en && cfg.controller_role_sel;
  assign slave  = cfg.port_en && !cfg.controller_role_sel;
  // Link shifter held in reset unless enabled as slave and selected; its toggles and rx_byte keep their state
  assign frame_rstn = rstn && slave && (ss_in == cfg.ss_act_high);

  sps_slave_link u_link (
    .link_clk   (link_sclk),
    .frame_rstn (frame_rstn),
    .rstn       (rstn),
    .invert     (cfg.cpol ^ cfg.cpha),
    .din        (mosi_in),
    .hold       (r.hold),
    .out_bit    (slave_out),
    .rx_byte    (link_rx),
    .tog_start  (tog_start),
    .tog_done   (tog_done)
  );

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  always_comb begin
    pins.ss_o    = r.ss_drv ? cfg.ss_act_high : ~cfg.ss_act_high;
    pins.ss_oe   = master && r.ss_drv;
    pins.sclk_o  = r.sclk_act ^ cfg.cpol;
    pins.sclk_oe = master;
    pins.mosi_o  = master ? r.mosi_r : slave_out;
    pins.mosi_oe = (master && (!cfg.three_wire || (r.cur_tx && r.mst != M_IDLE)))
                 || (slave && cfg.three_wire && cfg.slave_3w_tx && r.ss_p);
    pins.miso_o  = slave_out;
    pins.miso_oe = slave && !cfg.three_wire && r.ss_p;
  end

  assign start_pending = r.start_r;
  assign xfer_active   = (r.mst != M_IDLE);
  assign wr_busy       = (r.stg_n != 3'h0);
  assign rd_busy       = (r.rd_left != 3'h0);
  assign rd_valid      = r.rd_v;
  assign rd_data       = r.rdat;
  assign flags         = r.flg;
  assign wake_flags    = r.wflg;
  assign wake          = |r.wflg;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic                 ss_on;
    logic                 tick;
    logic                 hedge;
    logic                 din;
    logic                 stall;
    logic                 send;
    logic [3:0]           scl;
    logic [7:0]           lim;
    logic [7:0]           dur;
    logic [7:0]           rbyte;
    logic [NUM_FLAGS-1:0] ev;
    logic [NUM_WAKE-1:0]  wev;
    logic                 txl_c;
    logic                 rxl_c;
    n       = r;
    tx_push = 1'b0;
    tx_pop  = 1'b0;
    rx_push = 1'b0;
    rx_pop  = 1'b0;
    rx_wd   = 8'h00;
    ev      = '0;
    wev     = '0;
    stall   = 1'b0;
    send    = (r.txl != 16'h0000);
    tick    = 1'b0;
    n.rd_v  = 1'b0;
    ss_on   = 1'b0;
    hedge   = 1'b0;
    din     = 1'b0;
    scl     = 4'h0;
    lim     = 8'h00;
    dur     = 8'h01;
    rbyte   = 8'h00;
    txl_c   = 1'b0;
    rxl_c   = 1'b0;

    // Two-flop synchronisers; only s2 is looked at
    n.s1 = {tog_done, tog_start, miso_in, mosi_in, ss_in};
    n.s2 = r.s1;
    // Select is trusted only once both flops hold a real sample
    n.prime = {r.prime[0], 1'b1};
    ss_on  = cfg.port_en && r.prime[1] && (r.s2[SY_SS] == cfg.ss_act_high);
    n.ss_p = ss_on;
    n.ts_p = r.s2[SY_TS];
    n.td_p = r.s2[SY_TD];
    din    = cfg.three_wire ? r.s2[SY_MOSI] : r.s2[SY_MISO];

    // Select edges, slave frame end and abort
    if (ss_on != r.ss_p) ev[FL_SS_EDGE] = 1'b1;
    if (slave && r.ss_p && !ss_on) begin
      ev[FL_DONE] = 1'b1;
      if (r.s2[SY_TS] != r.s2[SY_TD]) ev[FL_ABORT] = 1'b1;
    end

    // Slave transmit hold register and receive path
    if (slave && r.s2[SY_TS] != r.ts_p) begin
      if (!r.hold_full) ev[FL_TX_UNDER] = 1'b1;
      n.hold_full = 1'b0;
    end
    if (r.refill) begin
      n.hold      = tx_rd;
      n.hold_full = 1'b1;
      n.refill    = 1'b0;
    end else if (slave && !n.hold_full && !tx_empty) begin
      tx_pop   = 1'b1;
      n.refill = 1'b1;
    end
    if (slave && r.s2[SY_TD] != r.td_p) begin
      if (rx_full) ev[FL_RX_OVER] = 1'b1;
      else begin
        rx_push = 1'b1;
        rx_wd   = link_rx;
      end
    end

    // Master clock divider: 2^scale clocks per tick with scale capped at SCALE_MAX, lo/hi ticks per half
    scl   = (cfg.scale > SCALE_MAX) ? SCALE_MAX : cfg.scale;
    lim   = 8'((9'h001 << scl) - 9'h001);
    dur   = (r.mst == M_B) ? ((cfg.hi == 8'h00) ? 8'h01 : cfg.hi)
                           : ((cfg.lo == 8'h00) ? 8'h01 : cfg.lo);
    if (r.mst == M_LEAD || r.mst == M_A || r.mst == M_B || r.mst == M_DONE) begin
      tick  = (r.psc == lim);
      n.psc = tick ? 8'h00 : r.psc + 8'h01;
    end else begin
      n.psc = 8'h00;
    end
    hedge  = tick && (r.hcnt == dur - 8'h01);
    n.hcnt = hedge ? 8'h00 : (tick ? r.hcnt + 8'h01 : r.hcnt);
    rbyte  = cfg.cpha ? {r.shin[6:0], din} : r.shin;
    // Own select release needs two clocks to leave the synchroniser
    n.drv_h = {r.drv_h[0], r.ss_drv};

    case (r.mst)
      M_IDLE: begin
        n.ss_drv = r.ss_drv && cfg.ss_hold;
        if (master && !r.ss_drv && r.drv_h == 2'h0 && ss_on) ev[FL_MM_FAULT] = 1'b1;
        else if (master && r.start_r) begin
          n.start_r = 1'b0;
          n.ss_drv  = 1'b1;
          n.txl     = cfg.tx_chars;
          n.rxl     = cfg.three_wire ? cfg.rx_chars : 16'h0000;
          n.mst     = M_LEAD;
        end
      end
      M_LEAD: if (hedge) n.mst = M_LOAD;
      M_LOAD: begin
        stall = (send && tx_empty)
             || ((!cfg.three_wire || !send) && rx_full);
        if (!send && r.rxl == 16'h0000) n.mst = M_DONE;
        else if (!stall) begin
          n.cur_tx = send;
          n.bitn   = 3'h0;
          if (send) begin
            tx_pop = 1'b1;
            n.mst  = M_FETCH;
          end else begin
            n.shout = 8'h00;
            n.mst   = M_A;
          end
        end
      end
      M_FETCH: begin
        n.shout = tx_rd;
        if (!cfg.cpha) n.mosi_r = tx_rd[7];
        n.mst = M_A;
      end
      M_A: if (hedge) begin
        n.sclk_act = 1'b1;
        if (!cfg.cpha) n.shin = {r.shin[6:0], din};
        else begin
          n.mosi_r = r.shout[7];
          n.shout  = {r.shout[6:0], 1'b0};
        end
        n.mst = M_B;
      end
      M_B: if (hedge) begin
        n.sclk_act = 1'b0;
        if (cfg.cpha) n.shin = {r.shin[6:0], din};
        else begin
          n.mosi_r = r.shout[6];
          n.shout  = {r.shout[6:0], 1'b0};
        end
        if (r.bitn == 3'h7) begin
          if (!cfg.three_wire || !r.cur_tx) begin
            rx_push = 1'b1;
            rx_wd   = rbyte;
          end
          if (r.cur_tx) n.txl = r.txl - 16'h0001;
          else n.rxl = r.rxl - 16'h0001;
          n.mst = M_LOAD;
        end else begin
          n.bitn = r.bitn + 3'h1;
          n.mst  = M_A;
        end
      end
      M_DONE: if (hedge) begin
        n.ss_drv    = cfg.ss_hold;
        ev[FL_DONE] = 1'b1;
        n.mst       = M_IDLE;
      end
      default: n.mst = M_IDLE;
    endcase

    // Losing the master role ends the transfer at once
    if (!master) begin
      n.mst      = M_IDLE;
      n.ss_drv   = 1'b0;
      n.sclk_act = 1'b0;
    end
    if (start_req) n.start_r = 1'b1;

    // Processor writes, staged and pushed one byte per clock
    if (r.stg_n != 3'h0) begin
      if (tx_full) ev[FL_TX_OVER] = 1'b1;
      else tx_push = 1'b1;
      n.stg   = {8'h00, r.stg[31:8]};
      n.stg_n = r.stg_n - 3'h1;
    end else if (wr.en) begin
      case (wr.size)
        SIZE_32: begin
          n.stg   = wr.data;
          n.stg_n = 3'h4;
        end
        SIZE_16: begin
          n.stg   = {16'h0000, wr.data[15:0]};
          n.stg_n = 3'h2;
        end
        default: begin
          if (wr.addr[0]) begin
            n.phi   = wr.data[7:0];
            n.phi_v = 1'b1;
          end else begin
            n.plo   = wr.data[7:0];
            n.plo_v = 1'b1;
          end
          if (n.plo_v && n.phi_v) begin
            n.stg   = {16'h0000, n.phi, n.plo};
            n.stg_n = 3'h2;
            n.plo_v = 1'b0;
            n.phi_v = 1'b0;
          end
        end
      endcase
    end

    // Processor reads, one byte per pop and capture
    if (r.rd_cap) begin
      n.rdat[8*r.rd_idx +: 8] = rx_rd;
      n.rd_cap  = 1'b0;
      n.rd_idx  = r.rd_idx + 2'h1;
      n.rd_left = r.rd_left - 3'h1;
      n.rd_v    = (r.rd_left == 3'h1);
    end else if (r.rd_left != 3'h0) begin
      if (rx_empty) begin
        ev[FL_RX_UNDER] = 1'b1;
        n.rdat[8*r.rd_idx +: 8] = IDLE_BYTE;
        n.rd_idx  = r.rd_idx + 2'h1;
        n.rd_left = r.rd_left - 3'h1;
        n.rd_v    = (r.rd_left == 3'h1);
      end else begin
        rx_pop   = 1'b1;
        n.rd_cap = 1'b1;
      end
    end else if (rd.en) begin
      n.rdat    = 32'h0000_0000;
      n.rd_idx  = 2'h0;
      n.rd_left = (rd.size == SIZE_32) ? 3'h4 : ((rd.size == SIZE_16) ? 3'h2 : 3'h1);
    end

    // FIFO condition crossings and wake sources
    txl_c   = ({1'b0, tx_count} <= {1'b0, cfg.tx_lvl});
    rxl_c   = (rx_count >= cfg.rx_lvl);
    n.txe_p = tx_empty;
    n.rxf_p = rx_full;
    n.txl_p = txl_c;
    n.rxl_p = rxl_c;
    ev[FL_TX_EMPTY] = tx_empty && !r.txe_p;
    ev[FL_RX_FULL]  = rx_full && !r.rxf_p;
    ev[FL_TX_LEVEL] = txl_c && !r.txl_p;
    ev[FL_RX_LEVEL] = rxl_c && !r.rxl_p;
    wev[WK_RX_FULL]  = ev[FL_RX_FULL];
    wev[WK_TX_EMPTY] = ev[FL_TX_EMPTY];
    wev[WK_RX_LEVEL] = ev[FL_RX_LEVEL];
    wev[WK_TX_LEVEL] = ev[FL_TX_LEVEL];

    // Sticky flags: a new event beats a clear in the same cycle
    n.flg  = (r.flg & ~flag_clr) | ev;
    n.wflg = (r.wflg & ~wake_clr) | (wev & wake_en);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) r <= '0;
    else if (ce) r <= n;
  end
endmodule : sps_port

/* File: sps_port_props.sv */
/*
  Checker bound to sps_port: write, read, start, flag and pin-enable timing.
  Assumes one system clock domain and ce driven by the surrounding bench.
*/
`timescale 1ns/100ps
module sps_port_props
  import sps_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic                 ce,
  input wire sps_pins_t            pins,
  input wire sps_cfg_t             cfg,
  input wire logic                 start_pending,
  input wire logic                 xfer_active,
  input wire sps_wr_t              wr,
  input wire logic                 wr_busy,
  input wire sps_rd_t              rd,
  input wire logic                 rd_busy,
  input wire logic                 rd_valid,
  input wire logic [NUM_FLAGS-1:0] flag_clr,
  input wire logic [NUM_FLAGS-1:0] flags,
  input wire logic [CNT_W-1:0]     tx_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_WR16: assert property (ce && wr.en && !wr_busy && wr.size == SIZE_16
    |=> wr_busy ##1 wr_busy ##1 !wr_busy) else $error("half-word push length wrong");
  AST_WR32: assert property (ce && wr.en && !wr_busy && wr.size == SIZE_32
    |=> wr_busy[*4] ##1 !wr_busy) else $error("word push length wrong");
  AST_RD8: assert property (ce && rd.en && !rd_busy && rd.size == SIZE_8
    |-> ##[1:3] rd_valid) else $error("byte read not answered");
  AST_STICKY: assert property (1'b1
    |=> (~flags & $past(flags & ~flag_clr)) == '0) else $error("flag lost without clear");
  AST_TXCNT: assert property (tx_count <= FIFO_BYTES) else $error("tx count too high");
  AST_START: assert property ($rose(xfer_active)
    |-> ##[0:1] !start_pending) else $error("start stays pending");
  AST_SCLK_OE: assert property (pins.sclk_oe == (cfg.port_en && cfg.controller_role_sel))
    else $error("clock drive wrong");
  AST_MISO_OE: assert property (cfg.controller_role_sel |-> !pins.miso_oe)
    else $error("master drives data in line");
endmodule : sps_port_props

bind sps_port sps_port_props u_props (.clk, .rstn, .ce, .pins, .cfg, .start_pending,
  .xfer_active, .wr, .wr_busy, .rd, .rd_busy, .rd_valid, .flag_clr, .flags, .tx_count);

/* File: sps_slave_model.sv */
/*
  External mode-0 slave: sends a counting byte stream, records the last 64 bits seen.
  Assumes sel is the active-high view of the select wire.
*/
`timescale 1ns/100ps
module sps_slave_model (
  input  wire logic        sclk,
  input  wire logic        sel,
  input  wire logic        mosi,
  input  wire logic [7:0]  first,
  output logic             miso,
  output logic [63:0]      got
);
  logic [7:0] sh;
  logic [7:0] nxt;
  int         bits;
  initial begin
    miso = 1'b0;
    got  = '0;
    bits = 0;
  end
  always @(posedge sel) begin
    nxt  = first;
    sh   = first;
    bits = 0;
    miso = sh[7];
  end
  // Released line shows the inverse, never the last bit
  always @(negedge sel) miso = ~miso;
  always @(posedge sclk) if (sel) begin
    got = {got[62:0], mosi};
    bits++;
  end
  always @(negedge sclk) if (sel) begin
    nxt = (bits % 8 == 0) ? nxt + 8'h01 : nxt;
    sh  = (bits % 8 == 0) ? nxt : {sh[6:0], 1'b0};
    miso = sh[7];
  end
endmodule : sps_slave_model

/* File: sps_port_bench.sv */
/*
  Bench for sps_port: master run against the slave model, then a slave run.
  Assumes the checker is bound and the slave model is compiled first.
*/
`timescale 1ns/100ps
module sps_port_bench;
  import sps_pkg::*;
  logic                 clk, rstn, bsclk, bss, bmosi, start_req, mmiso, ce;
  logic                 wr_busy, rd_busy, rd_valid, wake;
  sps_pins_t            pins;
  sps_cfg_t             cfg;
  sps_wr_t              wr;
  sps_rd_t              rd;
  logic [NUM_FLAGS-1:0] flag_clr, flags;
  logic [NUM_WAKE-1:0]  wake_clr, wake_flags, wake_en;
  logic [CNT_W-1:0]     tx_count, rx_count;
  logic [31:0]          rd_data;
  logic [63:0]          got;
  logic [7:0]           first;
  logic [7:0]           txq[$];
  logic [7:0]           rxq[$];
  int                   n_errors, total_checks, cyc;
  wire                  sclk_w = pins.sclk_oe ? pins.sclk_o : bsclk;
  wire                  ss_w = pins.ss_oe ? pins.ss_o : bss;
  sps_port dut (.clk(clk), .rstn(rstn), .ce(ce), .link_sclk(sclk_w), .ss_in(ss_w),
    .mosi_in(pins.mosi_oe ? pins.mosi_o : bmosi), .miso_in(pins.miso_oe ? pins.miso_o : mmiso),
    .pins(pins), .cfg(cfg), .start_req(start_req), .start_pending(), .xfer_active(),
    .wr(wr), .wr_busy(wr_busy), .rd(rd), .rd_busy(rd_busy), .rd_valid(rd_valid),
    .rd_data(rd_data), .flag_clr(flag_clr), .flags(flags), .wake_en(wake_en),
    .wake_clr(wake_clr), .wake_flags(wake_flags), .wake(wake), .tx_count(tx_count),
    .rx_count(rx_count));
  sps_slave_model slv (.sclk(sclk_w), .sel(!ss_w), .mosi(pins.mosi_o), .first(first),
    .miso(mmiso), .got(got));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrt(input logic [1:0] s, input logic [1:0] a, input logic [31:0] d);
    @(negedge clk);
    wr <= {1'b1, s, a, d};
    @(negedge clk);
    wr.en <= 1'b0;
    repeat (5) @(negedge clk);
  endtask : wrt
  task automatic rdt(input logic [1:0] s, output logic [31:0] d);
    int n;
    @(negedge clk);
    rd <= {1'b1, s};
    @(negedge clk);
    rd.en <= 1'b0;
    for (n = 0; n < 20 && rd_valid !== 1'b1; n++) @(negedge clk);
    d = rd_data;
  endtask : rdt
  task automatic pulse_clr();
    @(negedge clk);
    flag_clr <= '1;
    wake_clr <= '1;
    @(negedge clk);
    flag_clr <= '0;
    wake_clr <= '0;
    @(negedge clk);
  endtask : pulse_clr
  function automatic logic [31:0] pop_rx(input int n);
    logic [31:0] e;
    e = '0;
    for (int i = 0; i < n; i++) e[8*i+:8] = rxq.pop_front();
    return e;
  endfunction : pop_rx
  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    logic [31:0] d;
    logic [63:0] e;
    logic [15:0] h;
    logic [7:0]  m;
    logic [7:0]  s;
    int          k;
    void'($urandom(32'h80f6));
    h = 16'($urandom());
    m = 8'($urandom());
    first = 8'($urandom());
    wake_en = 4'($urandom());
    {ce, rstn, bsclk, bmosi, start_req, bss} = 6'h21;
    {flag_clr, wake_clr, wr, rd} = '0;
    cfg = '0;
    cfg.controller_role_sel = 1'b1;
    {cfg.hi, cfg.lo, cfg.tx_chars} = 32'h0404_0008;
    {cfg.tx_lvl, cfg.rx_lvl} = {6'h02, 6'h08};
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    chk(flags, '0);
    cfg.port_en = 1'b1;
    wrt(SIZE_16, 2'h0, {16'h0, h});
    wrt(SIZE_8, 2'h1, {24'h0, m});
    chk(tx_count, 6'h02);
    wrt(SIZE_8, 2'h0, {24'h0, ~m});
    wrt(SIZE_32, 2'h0, 32'hA1B2C3D4);
    txq = '{h[7:0], h[15:8], ~m, m, 8'hD4, 8'hC3, 8'hB2, 8'hA1};
    chk(tx_count, 6'h08);
    pulse_clr();
    start_req <= 1'b1;
    @(negedge clk);
    start_req <= 1'b0;
    for (k = 0; k < 4000 && flags[FL_DONE] !== 1'b1; k++) @(negedge clk);
    foreach (txq[i]) e = {e[55:0], txq[i]};
    chk(got, e);
    chk({flags[FL_DONE], flags[7:0]}, 9'h10B);
    chk(wake_flags, 4'hE & wake_en);
    for (k = 0; k < 8; k++) rxq.push_back(first + 8'(k));
    rdt(SIZE_32, d);
    chk(d, pop_rx(4));
    rdt(SIZE_16, d);
    chk(d, pop_rx(2));
    for (k = 0; k < 3; k++) begin
      rdt(SIZE_8, d);
      chk(d, (k < 2) ? pop_rx(1) : 32'hFF);
    end
    chk({flags[FL_MM_FAULT], flags[FL_RX_UNDER]}, 2'h1);
    pulse_clr();
    chk({wake, flags[FL_RX_UNDER]}, 2'h0);
    ce = 1'b0;
    wrt(SIZE_16, 2'h0, 32'h0000_5A5A);
    ce = 1'b1;
    chk(tx_count, 6'h00);
    cfg.port_en = 1'b0;
    cfg.controller_role_sel = 1'b0;
    {cfg.cpol, cfg.cpha, bsclk} = 3'h7;
    @(negedge clk);
    cfg.port_en = 1'b1;
    wrt(SIZE_16, 2'h0, {16'h0, h});
    bss <= 1'b0;
    repeat (4) @(negedge clk);
    #7;
    for (k = 7; k >= 0; k--) begin
      bsclk = 1'b0;
      bmosi = m[k];
      #24 s = {s[6:0], pins.miso_o};
      bsclk = 1'b1;
      #24;
    end
    chk(s, h[7:0]);
    @(negedge clk);
    bss <= 1'b1;
    bmosi <= ~bmosi;
    repeat (10) @(negedge clk);
    chk({rx_count, flags[FL_SS_EDGE]}, {6'h01, 1'b1});
    rdt(SIZE_8, d);
    chk(d, {24'h0, m});
    stop_test();
  end
endmodule : sps_port_bench
